// ===== hdl/eer_pkg.sv
// Functional notes
// - One message per distinct error event
// - Persisting error sends no repeat message
// - Code bytes 1-2, register 3, field 4-8
// - Code 0000 means reset or no error
// - Module 1000, axes 1001 to 1003
// - Applications 1010, axes 1011 to 1013
// - Register bits fixed, bit 6 zero
// - Field: detail word, index, value
// - Detail word follows module or axis source
// - Optional index 0..255 with 16-bit value
// - Every signalled error enters history
// - Count register holds recorded error count
// - New error at entry zero, others shift
// - Writing zero to count empties history
// - Entry: code low half, info high half
package eer_pkg;
  localparam int HIST_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam int IDX_W = 3;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_MODULE = 16'h1000;
  localparam logic [15:0] CODE_AXIS1 = 16'h1001;
  localparam logic [15:0] CODE_AXIS2 = 16'h1002;
  localparam logic [15:0] CODE_AXIS3 = 16'h1003;
  localparam logic [15:0] CODE_APP_MAIN = 16'h1010;
  localparam logic [15:0] CODE_APP_AX1 = 16'h1011;
  localparam logic [15:0] CODE_APP_AX2 = 16'h1012;
  localparam logic [15:0] CODE_APP_AX3 = 16'h1013;
  localparam logic [7:0] ERR_REG_MASK = 8'hBF;
  localparam int SRC_N = 8;
  localparam int SRC_W = 3;
  // Error register byte layout, bit 6 reserved
  typedef struct packed {
    logic manuf;
    logic rsvd;
    logic profile;
    logic comm;
    logic temp;
    logic voltage;
    logic current;
    logic generic;
  } eer_err_reg_t;
  // Eight-byte message, byte 1 in the top bits
  typedef struct packed {
    logic [15:0] code;
    eer_err_reg_t err_reg;
    logic [15:0] detail;
    logic [7:0] add_index;
    logic [15:0] add_value;
  } eer_msg_t;
  // Event request from one error source
  typedef struct packed {
    eer_err_reg_t err_reg;
    logic [15:0] detail;
    logic [7:0] add_index;
    logic [15:0] add_value;
  } eer_event_t;
endpackage

// ===== hdl/eer_hist_mem.sv
`timescale 1ns/1ps
// Shifting history store; read data registered
module eer_hist_mem (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic push,
  input wire logic clear,
  input wire logic [31:0] push_word,
  input wire logic [eer_pkg::IDX_W-1:0] rd_idx,
  output logic [31:0] rd_word_ff
);
  logic [31:0] mem_ff [eer_pkg::HIST_DEPTH];

  // Shift down on push; the last entry falls off when full
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < eer_pkg::HIST_DEPTH; i++) mem_ff[i] <= 32'h00000000;
    end else if (clk_en) begin
      if (push) begin
        mem_ff[0] <= push_word;
        // a clear on the same edge still empties the older entries
        for (int i = 1; i < eer_pkg::HIST_DEPTH; i++) mem_ff[i] <= clear ? 32'h00000000 : mem_ff[i-1];
      end else if (clear) begin
        for (int i = 0; i < eer_pkg::HIST_DEPTH; i++) mem_ff[i] <= 32'h00000000;
      end
    end
  end

  // Registered read port
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_word_ff <= 32'h00000000;
    end else if (clk_en) begin
      rd_word_ff <= mem_ff[rd_idx];
    end
  end
endmodule

// ===== hdl/eer_reporter.sv
`timescale 1ns/1ps
// Emergency message framer with error history
// Sources: 0 module, 1..3 axes, 4 main app, 5..7 app axes
module eer_reporter (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [eer_pkg::SRC_N-1:0] err_active,
  input eer_pkg::eer_event_t [eer_pkg::SRC_N-1:0] err_info,
  input wire logic reset_report,
  output logic msg_valid,
  input wire logic msg_ready,
  output eer_pkg::eer_msg_t msg_ff,
  output logic [eer_pkg::CNT_W-1:0] hist_count_ff,
  input wire logic hist_wr_count,
  input wire logic [7:0] hist_wr_data,
  input wire logic [eer_pkg::IDX_W-1:0] hist_rd_idx,
  output logic [31:0] hist_rd_word
);
  typedef enum logic [0:0] {EER_IDLE, EER_SEND} eer_state_t;
  eer_state_t state_ff;
  logic [eer_pkg::SRC_N-1:0] prev_ff;
  logic [eer_pkg::SRC_N-1:0] pend_ff;
  logic pend_reset_ff;
  logic [eer_pkg::SRC_N-1:0] rise;
  logic [eer_pkg::SRC_N-1:0] grant;
  logic [eer_pkg::SRC_W-1:0] grant_idx;
  logic load;
  logic load_reset;
  logic hist_clear;
  eer_pkg::eer_msg_t nxt_msg;
  logic [15:0] code_tab [eer_pkg::SRC_N];
  logic [15:0] module_detail;
  logic [15:0] axis3_detail;
  logic [15:0] axis3_value;

  assign code_tab[0] = eer_pkg::CODE_MODULE;
  assign code_tab[1] = eer_pkg::CODE_AXIS1;
  assign code_tab[2] = eer_pkg::CODE_AXIS2;
  assign code_tab[3] = eer_pkg::CODE_AXIS3;
  assign code_tab[4] = eer_pkg::CODE_APP_MAIN;
  assign code_tab[5] = eer_pkg::CODE_APP_AX1;
  assign code_tab[6] = eer_pkg::CODE_APP_AX2;
  assign code_tab[7] = eer_pkg::CODE_APP_AX3;

  // Copies of a few source fields, watched by the frame checks below
  assign module_detail = err_info[0].detail;
  assign axis3_detail = err_info[3].detail;
  assign axis3_value = err_info[3].add_value;

  assign rise = err_active & ~prev_ff;

  // Lowest pending source wins; others wait their turn
  always_comb begin
    grant = '0;
    grant_idx = '0;
    for (int i = eer_pkg::SRC_N - 1; i >= 0; i--) begin
      if (pend_ff[i]) begin
        grant = '0;
        grant[i] = 1'b1;
        grant_idx = eer_pkg::SRC_W'(i);
      end
    end
  end

  // Reset report takes precedence over errors
  assign load = (state_ff == EER_IDLE) && (pend_reset_ff || (pend_ff != '0));
  assign load_reset = load && pend_reset_ff;
  assign msg_valid = (state_ff == EER_SEND);

  // Edge history register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff <= '0;
    end else if (clk_en) begin
      prev_ff <= err_active;
    end
  end

  // only new edges re-arm; new event wins over grant clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_ff <= '0;
      pend_reset_ff <= 1'b0;
    end else if (clk_en) begin
      pend_ff <= (pend_ff & ~((load && !load_reset) ? grant : '0)) | rise;
      pend_reset_ff <= (pend_reset_ff & ~load_reset) | reset_report;
    end
  end

  // Message assembly
  always_comb begin
    nxt_msg = '0;
    if (!load_reset) begin
      nxt_msg.code = code_tab[grant_idx];
      nxt_msg.err_reg = eer_pkg::eer_err_reg_t'(8'(err_info[grant_idx].err_reg) & eer_pkg::ERR_REG_MASK);
      nxt_msg.detail = err_info[grant_idx].detail;
      nxt_msg.add_index = err_info[grant_idx].add_index;
      nxt_msg.add_value = err_info[grant_idx].add_value;
    end else begin
      nxt_msg.code = eer_pkg::CODE_NONE;
    end
  end

  // held frame, byte 1 on top
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      msg_ff <= '0;
      state_ff <= EER_IDLE;
    end else if (clk_en) begin
      case (state_ff)
        EER_IDLE: begin
          if (load) begin
            msg_ff <= nxt_msg;
            state_ff <= EER_SEND;
          end
        end
        EER_SEND: begin
          if (msg_ready) state_ff <= EER_IDLE;
        end
        default: state_ff <= EER_IDLE;
      endcase
    end
  end

  assign hist_clear = hist_wr_count && (hist_wr_data == 8'h00);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hist_count_ff <= eer_pkg::CNT_ZERO;
    end else if (clk_en) begin
      if (load && !load_reset) begin
        if (hist_clear) hist_count_ff <= eer_pkg::CNT_ONE;
        else if (hist_count_ff != eer_pkg::CNT_MAX) hist_count_ff <= hist_count_ff + eer_pkg::CNT_ONE;
      end else if (hist_clear) begin
        hist_count_ff <= eer_pkg::CNT_ZERO;
      end
    end
  end

  eer_hist_mem u_hist (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .push(load && !load_reset),
    .clear(hist_clear),
    .push_word({nxt_msg.detail, nxt_msg.code}),
    .rd_idx(hist_rd_idx),
    .rd_word_ff(hist_rd_word)
  );

  AST_BIT6_ZERO: assert property (@(posedge clock) disable iff (!arst_n) msg_valid |-> !msg_ff.err_reg.rsvd)
    else $error("reserved bit set");
  AST_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    msg_valid && !msg_ready && clk_en |=> msg_valid && $stable(msg_ff))
    else $error("frame changed while waiting");
  AST_ONE_MSG: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && ((rise & grant) == '0) |=> (pend_ff & $past(grant)) == '0)
    else $error("pending not cleared after send");
  AST_NO_REPEAT: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && pend_ff == '0 && rise == '0 |=> pend_ff == '0)
    else $error("pending without new edge");
  AST_CNT_MAX: assert property (@(posedge clock) disable iff (!arst_n) hist_count_ff <= eer_pkg::CNT_MAX)
    else $error("count above depth");
  AST_CLEAR: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && hist_clear && !load |=> hist_count_ff == eer_pkg::CNT_ZERO)
    else $error("history not emptied");
  AST_COUNT_UP: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && !hist_clear && hist_count_ff != eer_pkg::CNT_MAX
    |=> hist_count_ff == $past(hist_count_ff) + eer_pkg::CNT_ONE)
    else $error("count did not advance");
  AST_RESET_CODE: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load_reset |=> msg_valid && msg_ff.code == eer_pkg::CODE_NONE)
    else $error("reset message code wrong");
  AST_CODE_MAP: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && grant_idx == 3'h0 |=> msg_ff.code == eer_pkg::CODE_MODULE)
    else $error("module code wrong");

  // Frame content and history bookkeeping checks
  AST_CODE_AX3: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && grant_idx == 3'h3 |=> msg_ff.code == eer_pkg::CODE_AXIS3)
    else $error("axis code wrong");
  AST_CODE_APP: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && grant_idx == 3'h4 |=> msg_ff.code == eer_pkg::CODE_APP_MAIN)
    else $error("main application code wrong");
  AST_CODE_APP3: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && grant_idx == 3'h7 |=> msg_ff.code == eer_pkg::CODE_APP_AX3)
    else $error("axis application code wrong");
  AST_DETAIL_MOD: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && grant_idx == 3'h0 |=> msg_ff.detail == $past(module_detail))
    else $error("module detail word wrong");
  AST_DETAIL_AX3: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && grant_idx == 3'h3 |=> msg_ff.detail == $past(axis3_detail))
    else $error("axis detail word wrong");
  AST_VALUE_AX3: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && grant_idx == 3'h3 |=> msg_ff.add_value == $past(axis3_value))
    else $error("additional value wrong");
  AST_RESET_BODY: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load_reset |=> 8'(msg_ff.err_reg) == 8'h00 && msg_ff.detail == 16'h0000
    && msg_ff.add_index == 8'h00 && msg_ff.add_value == 16'h0000)
    else $error("reset message body not empty");
  AST_LOAD_VALID: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load |=> msg_valid)
    else $error("loaded frame not offered");
  AST_SATURATE: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && !hist_clear && hist_count_ff == eer_pkg::CNT_MAX
    |=> hist_count_ff == eer_pkg::CNT_MAX)
    else $error("count left its maximum");
  AST_CLEAR_PUSH: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load && !load_reset && hist_clear |=> hist_count_ff == eer_pkg::CNT_ONE)
    else $error("clear with push miscounted");
  AST_NO_RESET_PUSH: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && load_reset && !hist_clear |=> $stable(hist_count_ff))
    else $error("reset message recorded");
endmodule

// ===== test/eer_master_model.sv
`timescale 1ns/1ps
// Network master: takes frames, may stall to prove frames hold
module eer_master_model (
  input wire logic clock,
  input wire logic slow,
  input wire logic msg_valid,
  input eer_pkg::eer_msg_t msg_ff,
  output logic msg_ready,
  output eer_pkg::eer_msg_t last_msg,
  output int rx_cnt
);
  logic tog_ff;
  initial begin
    tog_ff = 1'b0;
    msg_ready = 1'b0;
    rx_cnt = 0;
    last_msg = '0;
  end
  // Slow mode offers ready only every other cycle
  always @(posedge clock) begin
    if (msg_valid && msg_ready) begin
      last_msg <= msg_ff;
      rx_cnt <= rx_cnt + 1;
    end
    tog_ff <= ~tog_ff;
    msg_ready <= slow ? tog_ff : 1'b1;
  end
endmodule

// ===== test/test_emergency_error_reporter.sv
`timescale 1ns/1ps
module test_emergency_error_reporter;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic slow = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] err_active = 8'h00;
  eer_pkg::eer_event_t [7:0] err_info;
  logic reset_report = 1'b0;
  logic hist_wr_count = 1'b0;
  logic [7:0] hist_wr_data = 8'h00;
  logic [2:0] hist_rd_idx = 3'h0;
  logic msg_valid, msg_ready;
  eer_pkg::eer_msg_t msg_ff, last_msg;
  logic [3:0] hist_count_ff;
  logic [31:0] hist_rd_word;
  int rx_cnt;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [15:0] codes [8] = '{16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h1010, 16'h1011, 16'h1012, 16'h1013};
  always #2.5 clock = ~clock;
  eer_reporter dut_u (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .err_active(err_active),
    .err_info(err_info), .reset_report(reset_report), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_ff(msg_ff), .hist_count_ff(hist_count_ff), .hist_wr_count(hist_wr_count),
    .hist_wr_data(hist_wr_data), .hist_rd_idx(hist_rd_idx), .hist_rd_word(hist_rd_word));
  eer_master_model master_u (.clock(clock), .slow(slow), .msg_valid(msg_valid), .msg_ff(msg_ff),
    .msg_ready(msg_ready), .last_msg(last_msg), .rx_cnt(rx_cnt));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_rx(input int n);
    for (int k = 0; k < 60 && rx_cnt < n; k++) @(posedge clock);
    #1;
  endtask
  // Raise one source and judge the frame it yields
  task automatic fire(input int s);
    int n0;
    n0 = rx_cnt;
    @(posedge clock) err_active[s] <= 1'b1;
    wait_rx(n0 + 1);
    chk(rx_cnt, n0 + 1);
    chk(last_msg, {codes[s], 8'hBF, 8'hD0, 8'(s), 8'(s), 8'h5A, 8'(s)});
  endtask
  task automatic rd_hist(input int i, input logic [31:0] exp);
    @(posedge clock) hist_rd_idx <= i[2:0];
    repeat (2) @(posedge clock);
    #1 chk(hist_rd_word, exp);
  endtask
  task automatic test_single();
    fire(1);
    repeat (20) @(posedge clock);
    #1 chk(rx_cnt, 1);
    chk(msg_valid, 1'b0);
    chk(hist_count_ff, 4'h1);
    rd_hist(0, {16'hD001, 16'h1001});
    @(posedge clock) err_active <= 8'h00;
    $display("test_single done");
  endtask
  // Every source once under stalls; nine pushes overfill depth eight
  task automatic test_codes();
    slow <= 1'b1;
    for (int s = 0; s < 8; s++) fire(s);
    chk(hist_count_ff, 4'h8);
    rd_hist(0, {16'hD007, 16'h1013});
    rd_hist(1, {16'hD006, 16'h1012});
    rd_hist(7, {16'hD000, 16'h1000});
    @(posedge clock) err_active <= 8'h00;
    slow <= 1'b0;
    $display("test_codes done");
  endtask
  task automatic test_reset_msg();
    int n0;
    n0 = rx_cnt;
    @(posedge clock) reset_report <= 1'b1;
    @(posedge clock) reset_report <= 1'b0;
    wait_rx(n0 + 1);
    chk(last_msg, 64'h0);
    chk(hist_count_ff, 4'h8);
    $display("test_reset_msg done");
  endtask
  task automatic wr_count(input logic [7:0] d);
    @(posedge clock) hist_wr_count <= 1'b1;
    hist_wr_data <= d;
    @(posedge clock) hist_wr_count <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic test_clear();
    int n0;
    wr_count(8'h05);
    #1 chk(hist_count_ff, 4'h8);
    wr_count(8'h00);
    #1 chk(hist_count_ff, 4'h0);
    fire(3);
    chk(hist_count_ff, 4'h1);
    // Clear on the same edge as a push: the new entry stays, the rest goes
    n0 = rx_cnt;
    @(posedge clock) err_active[2] <= 1'b1;
    @(posedge clock) hist_wr_count <= 1'b1;
    hist_wr_data <= 8'h00;
    @(posedge clock) hist_wr_count <= 1'b0;
    wait_rx(n0 + 1);
    chk(hist_count_ff, 4'h1);
    rd_hist(0, {16'hD002, 16'h1002});
    rd_hist(1, 32'h00000000);
    $display("test_clear done");
  endtask
  // Reset report and two sources at one edge: reset first, then lowest source
  task automatic test_order();
    int n0;
    n0 = rx_cnt;
    @(posedge clock) err_active <= 8'h00;
    @(posedge clock) err_active <= 8'h22;
    reset_report <= 1'b1;
    @(posedge clock) reset_report <= 1'b0;
    wait_rx(n0 + 1);
    chk(last_msg, 64'h0);
    wait_rx(n0 + 2);
    chk(last_msg, {codes[1], 8'hBF, 8'hD0, 8'h01, 8'h01, 8'h5A, 8'h01});
    wait_rx(n0 + 3);
    chk(last_msg, {codes[5], 8'hBF, 8'hD0, 8'h05, 8'h05, 8'h5A, 8'h05});
    chk(hist_count_ff, 4'h3);
    rd_hist(0, {16'hD005, 16'h1011});
    rd_hist(1, {16'hD001, 16'h1001});
    rd_hist(2, {16'hD002, 16'h1002});
    @(posedge clock) err_active <= 8'h00;
    $display("test_order done");
  endtask
  // Frozen clock enable: the edge waits and is reported once enabled
  task automatic test_freeze();
    int n0;
    n0 = rx_cnt;
    @(posedge clock) clk_en <= 1'b0;
    err_active[6] <= 1'b1;
    repeat (10) @(posedge clock);
    #1 chk(rx_cnt, n0);
    chk(msg_valid, 1'b0);
    @(posedge clock) clk_en <= 1'b1;
    wait_rx(n0 + 1);
    chk(last_msg, {codes[6], 8'hBF, 8'hD0, 8'h06, 8'h06, 8'h5A, 8'h06});
    chk(hist_count_ff, 4'h4);
    @(posedge clock) err_active <= 8'h00;
    $display("test_freeze done");
  endtask
  // Reset in mid-run empties the history and idles the frame output
  task automatic test_reset_mid();
    @(posedge clock) arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk(hist_count_ff, 4'h0);
    chk(msg_valid, 1'b0);
    chk(hist_rd_word, 32'h00000000);
    @(posedge clock) arst_n <= 1'b1;
    fire(4);
    chk(hist_count_ff, 4'h1);
    rd_hist(1, 32'h00000000);
    @(posedge clock) err_active <= 8'h00;
    $display("test_reset_mid done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 8; i++) err_info[i] = {8'hFF, 8'hD0, 8'(i), 8'(i), 8'h5A, 8'(i)};
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    test_single();
    test_codes();
    test_reset_msg();
    test_clear();
    test_order();
    test_freeze();
    test_reset_mid();
    complete_run();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
endmodule
